// [include/tick_timer_pkg.sv]
/*
  Constants for the system tick timer: register offsets, field positions,
  reset values and timing counts.
  Assumes a 100 MHz core clock and an APB register port of 32-bit words.
*/
package tick_timer_pkg;

  localparam int ADDR_WIDTH = 12;
  localparam int DATA_WIDTH = 32;
  localparam int COUNT_WIDTH = 24;

  // Byte addresses of the registers
  localparam logic [11:0] TICK_CONTROL_OFFSET = 12'h010;
  localparam logic [11:0] TICK_RELOAD_OFFSET = 12'h014;
  localparam logic [11:0] TICK_CURRENT_COUNT_OFFSET = 12'h018;
  localparam logic [11:0] TICK_CALIBRATION_OFFSET = 12'h01C;
  localparam logic [11:0] TICK_IRQ_STATUS_OFFSET = 12'h020;
  localparam logic [11:0] TICK_IRQ_MASK_OFFSET = 12'h024;

  // Control and status fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_PEND_ENABLE_BIT = 1;
  localparam int CTRL_CLOCK_SELECT_BIT = 2;
  localparam int CTRL_ZERO_FLAG_BIT = 16;

  // Calibration fields
  localparam int CALIB_NO_REF_BIT = 31;
  localparam int CALIB_INEXACT_BIT = 30;

  // Interrupt status and mask fields
  localparam int IRQ_EVENTS = 2;
  localparam int IRQ_WRAP_BIT = 0;
  localparam int IRQ_CLEARED_BIT = 1;

  // Reset values
  localparam logic NO_REF_RESET = 1'b0;
  localparam logic INEXACT_RESET = 1'b1;
  localparam logic [23:0] CALIB_COUNT_RESET = 24'h000000;
  localparam logic [23:0] COUNT_RESET = 24'h000000;
  localparam logic [23:0] RELOAD_RESET = 24'h000000;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int REF_DIVIDE = 64;
  localparam int TEN_MS_US = 10000;
  localparam int CALIB_TEN_MS_TICKS = (TEN_MS_US * 1000) / (CLOCK_PERIOD_NS * REF_DIVIDE);
  localparam logic [23:0] CALIB_TEN_MS_VALUE = 24'(CALIB_TEN_MS_TICKS);
  localparam logic [5:0] REF_DIVIDE_LAST = 6'(REF_DIVIDE - 1);

endpackage

// [logic/ref_tick_divider.sv]
/*
  Divides the core clock by 64 into a one-cycle reference tick enable.
  Assumes the reference clock is fosc/64 derived from the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ref_tick_divider
  import tick_timer_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  output logic ref_tick
);

  typedef struct packed {
    logic [5:0] phase;
    logic tick;
  } divider_state_type;

  divider_state_type state_q;
  divider_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.tick = (state_q.phase == REF_DIVIDE_LAST);
    state_d.phase = state_q.phase + 6'h01;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
    end
    else if (clock_enable)
    begin
      state_q <= state_d;
    end
  end

  assign ref_tick = state_q.tick;

endmodule
`default_nettype wire

// [logic/strap_sync.sv]
/*
  Two flip-flop synchroniser for slowly changing strap inputs.
  Assumes the inputs stay stable for many cycles; no bus coherence is given.
*/
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_type;

  sync_state_type state_q;
  sync_state_type state_d;

  always_comb
  begin
    state_d.first = async_in;
    state_d.second = state_q.first;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
    end
    else if (clock_enable)
    begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.second;

endmodule
`default_nettype wire

// [logic/core_tick_timer_count_calib.sv]
/*
  System tick timer: 24-bit down counter with control, reload, current-count
  and calibration registers, an event status/mask pair and one interrupt line.
  Assumes an APB master on the core clock and static calibration straps.
*/
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module core_tick_timer_count_calib
  import tick_timer_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic no_ref_clock_in,
  input wire logic [23:0] calib_count_in,
  output logic irq,
  output logic tick_request
);

  // Register decode result; binary codes keep the compare narrow
  typedef enum logic [2:0] {
    REG_NONE = 3'b000,
    REG_CONTROL = 3'b001,
    REG_RELOAD = 3'b010,
    REG_CURRENT = 3'b011,
    REG_CALIBRATION = 3'b100,
    REG_IRQ_STATUS = 3'b101,
    REG_IRQ_MASK = 3'b110
  } register_select_type;

  typedef struct packed {
    logic [23:0] count;
    logic [23:0] reload;
    logic enable;
    logic pend_enable;
    logic clock_select;
    logic zero_flag;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic no_ref_clock;
    logic calib_inexact;
    logic [23:0] calib_ten_ms_count;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic irq;
    logic tick_request;
  } timer_state_type;

  timer_state_type state_q;
  timer_state_type state_d;

  logic ref_tick;
  logic no_ref_sync;
  logic [23:0] calib_sync;

  ref_tick_divider u_ref_tick_divider (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .ref_tick(ref_tick)
  );

  // Straps come from outside the clock domain
  strap_sync #(.WIDTH(25)) u_strap_sync (
    .clock(clock),
    .reset_n(reset_n),
    .clock_enable(clock_enable),
    .async_in({no_ref_clock_in, calib_count_in}),
    .sync_out({no_ref_sync, calib_sync})
  );

  function automatic register_select_type decode_register(input logic [11:0] addr);
    if (addr == TICK_CONTROL_OFFSET)
    begin
      decode_register = REG_CONTROL;
    end
    else if (addr == TICK_RELOAD_OFFSET)
    begin
      decode_register = REG_RELOAD;
    end
    else if (addr == TICK_CURRENT_COUNT_OFFSET)
    begin
      decode_register = REG_CURRENT;
    end
    else if (addr == TICK_CALIBRATION_OFFSET)
    begin
      decode_register = REG_CALIBRATION;
    end
    else if (addr == TICK_IRQ_STATUS_OFFSET)
    begin
      decode_register = REG_IRQ_STATUS;
    end
    else if (addr == TICK_IRQ_MASK_OFFSET)
    begin
      decode_register = REG_IRQ_MASK;
    end
    else
    begin
      decode_register = REG_NONE;
    end
  endfunction

  function automatic logic is_mapped(input logic [11:0] addr);
    is_mapped = (decode_register(addr) != REG_NONE);
  endfunction

  // Zero reload holds the count at zero with no wrap event
  function automatic logic [23:0] next_count(input logic [23:0] count, input logic [23:0] reload);
    if (count == COUNT_RESET)
    begin
      next_count = reload;
    end
    else
    begin
      next_count = count - 24'h000001;
    end
  endfunction

  function automatic logic reaches_zero(input logic [23:0] count);
    reaches_zero = (count == 24'h000001);
  endfunction

  // Without a reference clock the slow source never ticks
  function automatic logic tick_source(input logic core_sel, input logic ref_in, input logic no_ref);
    tick_source = core_sel || (ref_in && !no_ref);
  endfunction

  function automatic logic [1:0] event_bits(input logic wrap, input logic cleared);
    logic [1:0] bits;
    bits = 2'h0;
    bits[IRQ_WRAP_BIT] = wrap;
    bits[IRQ_CLEARED_BIT] = cleared;
    event_bits = bits;
  endfunction

  // Set wins over a one-written clear in the same cycle
  function automatic logic [1:0] status_next(input logic [1:0] s, input logic [1:0] c,
                                             input logic [1:0] ev);
    status_next = (s & ~c) | ev;
  endfunction

  function automatic logic [31:0] read_word(input logic [11:0] addr, input timer_state_type s);
    logic [31:0] word;
    word = 32'h00000000;
    if (addr == TICK_CONTROL_OFFSET)
    begin
      word[CTRL_ENABLE_BIT] = s.enable;
      word[CTRL_PEND_ENABLE_BIT] = s.pend_enable;
      word[CTRL_CLOCK_SELECT_BIT] = s.clock_select;
      word[CTRL_ZERO_FLAG_BIT] = s.zero_flag;
    end
    else if (addr == TICK_RELOAD_OFFSET)
    begin
      word[23:0] = s.reload;
    end
    else if (addr == TICK_CURRENT_COUNT_OFFSET)
    begin
      word[23:0] = s.count;
    end
    else if (addr == TICK_CALIBRATION_OFFSET)
    begin
      word[CALIB_NO_REF_BIT] = s.no_ref_clock;
      word[CALIB_INEXACT_BIT] = s.calib_inexact;
      word[23:0] = s.calib_ten_ms_count;
    end
    else if (addr == TICK_IRQ_STATUS_OFFSET)
    begin
      word[1:0] = s.irq_status;
    end
    else if (addr == TICK_IRQ_MASK_OFFSET)
    begin
      word[1:0] = s.irq_mask;
    end
    read_word = word;
  endfunction

  always_comb
  begin
    logic setup;
    logic done;
    logic wr;
    logic rd;
    logic count_tick;
    logic reached_zero;
    logic write_clear;
    logic enabling;
    logic flag_read_clear;
    logic [1:0] events;
    logic [1:0] w1c;
    register_select_type sel;
    sel = REG_NONE;
    setup = 1'b0;
    done = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    count_tick = 1'b0;
    reached_zero = 1'b0;
    write_clear = 1'b0;
    enabling = 1'b0;
    flag_read_clear = 1'b0;
    events = 2'h0;
    w1c = 2'h0;
    state_d = state_q;

    // No wait state: data is registered in setup so every output is a flop
    setup = psel && !penable;
    done = psel && penable && state_q.ready;
    wr = done && pwrite;
    rd = done && !pwrite;
    sel = decode_register(paddr);
    state_d.ready = setup;
    if (setup)
    begin
      state_d.rdata = pwrite ? 32'h00000000 : read_word(paddr, state_q);
      state_d.slverr = !is_mapped(paddr);
    end
    else if (done)
    begin
      state_d.rdata = 32'h00000000;
      state_d.slverr = 1'b0;
    end

    // Calibration fields follow the straps only, never the bus
    state_d.no_ref_clock = no_ref_sync;
    state_d.calib_ten_ms_count = calib_sync;
    state_d.calib_inexact = (state_q.calib_ten_ms_count != CALIB_TEN_MS_VALUE);

    // Counting tick from the selected source; no reference means no ticks from the reference source, core clock ticks go on
    count_tick = state_q.enable &&
                 tick_source(state_q.clock_select, ref_tick, state_q.no_ref_clock);

    if (wr)
    begin
      if (sel == REG_CONTROL)
      begin
        enabling = pwdata[CTRL_ENABLE_BIT] && !state_q.enable;
        state_d.enable = pwdata[CTRL_ENABLE_BIT];
        state_d.pend_enable = pwdata[CTRL_PEND_ENABLE_BIT];
        state_d.clock_select = pwdata[CTRL_CLOCK_SELECT_BIT];
      end
      else if (sel == REG_RELOAD)
      begin
        state_d.reload = pwdata[23:0];
      end
      else if (sel == REG_IRQ_MASK)
      begin
        state_d.irq_mask = pwdata[1:0];
      end
      else if (sel == REG_IRQ_STATUS)
      begin
        w1c = pwdata[1:0];
      end
    end
    write_clear = wr && (sel == REG_CURRENT);

    // Counter: write clear beats a tick, enabling beats both
    if (enabling)
    begin
      state_d.count = state_q.reload;
    end
    else if (write_clear)
    begin
      state_d.count = COUNT_RESET;
    end
    else if (count_tick)
    begin
      state_d.count = next_count(state_q.count, state_q.reload);
      reached_zero = reaches_zero(state_q.count);
    end

    // A read clears only a flag value already handed out in read data; a current-count write clears it always
    flag_read_clear = rd && (paddr == TICK_CONTROL_OFFSET) && state_q.rdata[CTRL_ZERO_FLAG_BIT];
    if (reached_zero)
    begin
      state_d.zero_flag = 1'b1;
    end
    else if (write_clear)
    begin
      state_d.zero_flag = 1'b0;
    end
    else if (flag_read_clear)
    begin
      state_d.zero_flag = 1'b0;
    end

    events = event_bits(reached_zero, write_clear);
    state_d.irq_status = status_next(state_q.irq_status, w1c, events);
    state_d.irq = |(state_d.irq_status & state_d.irq_mask);
    state_d.tick_request = reached_zero && state_q.pend_enable;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= '0;
      state_q.count <= COUNT_RESET;
      state_q.reload <= RELOAD_RESET;
      state_q.irq_mask <= IRQ_MASK_RESET;
      state_q.no_ref_clock <= NO_REF_RESET;
      state_q.calib_inexact <= INEXACT_RESET;
      state_q.calib_ten_ms_count <= CALIB_COUNT_RESET;
    end
    else if (clock_enable)
    begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.slverr;
  assign irq = state_q.irq;
  assign tick_request = state_q.tick_request;

endmodule
`default_nettype wire

// [tb/core_tick_timer_count_calib_chk.sv]
/*
  Port-level checker for the tick timer block, bound to its top module.
  Assumes one clock domain and the package compiled before this file.
*/
`timescale 1ns/1ps
`default_nettype none
module core_tick_timer_count_calib_chk
  import tick_timer_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic tick_request
);
  logic rd_acc;
  logic mapped;
  assign rd_acc = psel && penable && pready && !pwrite;
  assign mapped = paddr inside {TICK_CONTROL_OFFSET, TICK_RELOAD_OFFSET,
    TICK_CURRENT_COUNT_OFFSET, TICK_CALIBRATION_OFFSET, TICK_IRQ_STATUS_OFFSET,
    TICK_IRQ_MASK_OFFSET};
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_data_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  a_count_upper: assert property (
    rd_acc && paddr == TICK_CURRENT_COUNT_OFFSET |-> prdata[31:24] == 8'h0)
    else $error("count upper byte not zero");
  a_calib_gap: assert property (
    rd_acc && paddr == TICK_CALIBRATION_OFFSET |-> prdata[29:24] == 6'h0)
    else $error("calibration gap not zero");
  a_ctrl_zeros: assert property (
    rd_acc && paddr == TICK_CONTROL_OFFSET |-> (prdata & 32'hFFFEFFF8) == 32'h0)
    else $error("control spare bits set");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("error response wrong");
  a_calib_ro_ok: assert property (
    pready && pwrite && paddr == TICK_CALIBRATION_OFFSET |-> !pslverr)
    else $error("calibration write refused");
  a_pulse_gap: assert property (tick_request |=> !tick_request)
    else $error("pulse twice in a row");
  c_tick: cover property (tick_request);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pready && pslverr);
endmodule
bind core_tick_timer_count_calib core_tick_timer_count_calib_chk i_chk (.clock, .reset_n,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .irq, .tick_request);
`default_nettype wire

// [tb/core_tick_timer_count_calib_test.sv]
/*
  Self-checking bench for the tick timer block, with an APB master.
  Assumes the package, design and checker files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module core_tick_timer_count_calib_test
  import tick_timer_pkg::*;
;
  logic clock, reset_n, clock_enable, psel, penable, pwrite, pready, pslverr;
  logic no_ref_clock_in, irq, tick_request, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r, x;
  logic [23:0] calib_count_in;
  int miscompares, checks_done, cyc, t0, t1, n, v1, k;
  core_tick_timer_count_calib i_dut (.clock, .reset_n, .clock_enable, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .no_ref_clock_in,
    .calib_count_in, .irq, .tick_request);
  initial
  begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    checks_done++;
    if (sn !== ex)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    t0 = cyc;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1 && i < 20)
    begin
      @(posedge clock);
      i++;
    end
    if (i >= 20)
      miscompares++;
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
    chk("write error", 32'h0, e);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'h0, a, 32'h0);
    chk(nm, ex, r);
  endtask
  task automatic irq_is(input logic ex);
    repeat (2) @(posedge clock);
    chk("irq", ex, irq);
  endtask
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    miscompares++;
    wrap_up();
  end
  initial
  begin
    reset_n = 1'h0;
    clock_enable = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    no_ref_clock_in = 1'h0;
    calib_count_in = 24'h0;
    void'($urandom(32'h4C84ACB1));
    repeat (3) @(posedge clock);
    reset_n <= 1'h1;
    rd("calib reset", TICK_CALIBRATION_OFFSET, 32'h40000000);
    $display("Test reset done");
    for (int i = 0; i < 4; i++)
    begin
      no_ref_clock_in <= !i[0];
      calib_count_in <= (i == 1 || i == 2) ? CALIB_TEN_MS_VALUE : 24'($urandom);
      repeat (10) @(posedge clock);
      x = {no_ref_clock_in, calib_count_in != CALIB_TEN_MS_VALUE, 6'h0, calib_count_in};
      rd("calib", TICK_CALIBRATION_OFFSET, x);
      wr(TICK_CALIBRATION_OFFSET, $urandom);
      rd("calib kept", TICK_CALIBRATION_OFFSET, x);
    end
    $display("Test calibration done");
    n = 5 + $urandom % 20;
    wr(TICK_RELOAD_OFFSET, n);
    wr(TICK_CONTROL_OFFSET, 32'h5);
    apb(1'h0, TICK_CURRENT_COUNT_OFFSET, 32'h0);
    v1 = r;
    t1 = t0;
    apb(1'h0, TICK_CURRENT_COUNT_OFFSET, 32'h0);
    chk("count", ((v1 - t0 + t1) % (n + 1) + n + 1) % (n + 1), r);
    chk("count range", 1, v1 <= n);
    repeat (60) @(posedge clock);
    wr(TICK_CONTROL_OFFSET, 32'h4);
    rd("flag set", TICK_CONTROL_OFFSET, 32'h10004);
    rd("flag read clear", TICK_CONTROL_OFFSET, 32'h4);
    wr(TICK_CONTROL_OFFSET, 32'h5);
    repeat (60) @(posedge clock);
    wr(TICK_CONTROL_OFFSET, 32'h4);
    wr(TICK_CURRENT_COUNT_OFFSET, $urandom);
    rd("count cleared", TICK_CURRENT_COUNT_OFFSET, 32'h0);
    rd("flag write clear", TICK_CONTROL_OFFSET, 32'h4);
    $display("Test count done");
    wr(TICK_IRQ_MASK_OFFSET, 32'h1);
    wr(TICK_IRQ_STATUS_OFFSET, 32'h3);
    irq_is(1'h0);
    wr(TICK_CONTROL_OFFSET, 32'h7);
    k = 0;
    while (tick_request !== 1'h1 && k < 60)
    begin
      @(posedge clock);
      k++;
    end
    chk("pend pulse", 1, tick_request);
    irq_is(1'h1);
    wr(TICK_CONTROL_OFFSET, 32'h0);
    wr(TICK_IRQ_STATUS_OFFSET, 32'h3);
    irq_is(1'h0);
    rd("status clear", TICK_IRQ_STATUS_OFFSET, 32'h0);
    wr(TICK_CURRENT_COUNT_OFFSET, $urandom);
    irq_is(1'h0);
    wr(TICK_IRQ_MASK_OFFSET, 32'h3);
    irq_is(1'h1);
    rd("status write", TICK_IRQ_STATUS_OFFSET, 32'h2);
    wr(TICK_IRQ_STATUS_OFFSET, 32'h2);
    irq_is(1'h0);
    $display("Test interrupt done");
    wr(TICK_RELOAD_OFFSET, 32'h3E8);
    wr(TICK_CONTROL_OFFSET, 32'h1);
    apb(1'h0, TICK_CURRENT_COUNT_OFFSET, 32'h0);
    v1 = r;
    t1 = t0;
    repeat (640) @(posedge clock);
    apb(1'h0, TICK_CURRENT_COUNT_OFFSET, 32'h0);
    k = (t0 - t1) / 64;
    chk("ref ticks", 1, (v1 - r == k) || (v1 - r == k + 1));
    $display("Test reference done");
    apb(1'h0, 12'h0FC, 32'h0);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, r);
    apb(1'h1, 12'h0FC, $urandom);
    chk("unmapped write", 1, e);
    $display("Test unmapped done");
    wrap_up();
  end
endmodule
`default_nettype wire
